// ===== design/pwm_event_pkg.sv
// Package with modes, widths, field layouts and register map of the event router.
package pwm_event_pkg;

    localparam int CNT_W = 16;
    localparam int DT_W = 10;
    localparam int NUM_CMP = 6;
    localparam int SEL_W = 6;

    // ------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        MODE_INTERVAL = 4'h0,
        MODE_EXT_EVENT = 4'h1,
        MODE_EXT_TRIG = 4'h2,
        MODE_ONE_SHOT = 4'h3,
        MODE_PWM = 4'h4,
        MODE_FREE_RUN = 4'h5,
        MODE_PULSE_MEAS = 4'h6,
        MODE_TRI_PWM = 4'h7,
        MODE_HA_TPWM = 4'h8,
        MODE_DT_PWM = 4'h9
    } timer_mode_e;

    // ------------------------------------------------------------
    // Trigger select field layout
    // ------------------------------------------------------------
    localparam int SEL_PEAK_BIT = 2;
    localparam int SEL_CC4_BIT = 3;
    localparam int SEL_CC5_BIT = 4;

    // ------------------------------------------------------------
    // Counter state carried from the counter core
    // ------------------------------------------------------------
    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic down;
        logic peak_turn;
        logic valley_turn;
        logic overflow;
        logic error;
    } counter_state_s;

    typedef struct packed {
        logic [CNT_W-1:0] cycle_compare_reg;
        logic [CNT_W-1:0] first_dead_time;
        logic [CNT_W-1:0] second_dead_time;
    } cycle_setting_s;

    // ------------------------------------------------------------
    // AXI4-Lite register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [7:0] ADDR_TRIG_SEL = 8'h0C;
    localparam logic [7:0] ADDR_PIN = 8'h10;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MODE_W = 4;
    localparam int TRIG_B_LSB = 8;

    localparam int EV_W = 12;
    localparam int EV_CC0 = 0;
    localparam int EV_PEAK = 6;
    localparam int EV_VALLEY = 7;
    localparam int EV_OVF = 8;
    localparam int EV_ERR = 9;
    localparam int EV_TRIG_A = 10;
    localparam int EV_TRIG_B = 11;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== design/adc_trigger_ctrl.sv
// One A/D start trigger controller: ORs the selected event sources.
module adc_trigger_ctrl
    import pwm_event_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic [SEL_W-1:0] select,
    input wire logic peak_ev,
    input wire logic cc4_ev,
    input wire logic cc5_ev,
    output logic trigger
);

    logic next_trigger;

    always_comb begin
        next_trigger = enable & ((select[SEL_PEAK_BIT] & peak_ev) |
                                 (select[SEL_CC4_BIT] & cc4_ev) |
                                 (select[SEL_CC5_BIT] & cc5_ev));
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            trigger <= 1'b0;
        end else begin
            trigger <= next_trigger;
        end
    end

endmodule

// ===== design/pwm_timer_event_routing.sv
// Event, interrupt and A/D trigger routing of the multi-mode PWM timer.
module pwm_timer_event_routing
    import pwm_event_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire counter_state_s cnt_state,
    input wire cycle_setting_s cycle_set,
    input wire logic [NUM_CMP*CNT_W-1:0] duty_compare_reg,
    input wire logic thin_peak_pass,
    input wire logic thin_valley_pass,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [NUM_CMP-1:0] match_irq,
    output logic peak_irq,
    output logic valley_irq,
    output logic overflow_irq,
    output logic error_irq,
    output logic adc_start_trigger_a,
    output logic adc_start_trigger_b,
    output logic adc_trigger_pulse_pin,
    output logic irq
);

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    timer_mode_e mode;
    logic [SEL_W-1:0] trigger_a_select;
    logic [SEL_W-1:0] trigger_b_select;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;

    logic pwm_family;
    logic tri_mode;
    logic saw_mode;
    logic [NUM_CMP-1:0] raw_match;
    logic [NUM_CMP-1:0] next_match;
    logic next_peak;
    logic next_valley;
    logic next_ovf;
    logic next_err;
    logic [CNT_W-1:0] cyc;
    logic [CNT_W-1:0] dt0;
    logic [CNT_W-1:0] dt1;
    logic [CNT_W:0] upper_ha;
    logic [CNT_W:0] upper_dt;

    assign cyc = cycle_set.cycle_compare_reg;
    assign dt0 = cycle_set.first_dead_time;
    assign dt1 = cycle_set.second_dead_time;
    assign upper_ha = {1'b0, cyc} - {1'b0, dt1};
    assign upper_dt = {1'b0, cyc} + {1'b0, dt0};

    always_comb begin
        pwm_family = (mode == MODE_PWM) || (mode == MODE_TRI_PWM) ||
                     (mode == MODE_HA_TPWM) || (mode == MODE_DT_PWM);
        tri_mode = (mode == MODE_TRI_PWM) || (mode == MODE_HA_TPWM);
        saw_mode = (mode == MODE_PWM) || (mode == MODE_DT_PWM);
    end

    // ------------------------------------------------------------
    // Compare match generation
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CMP; gi++) begin : g_match
            logic [CNT_W-1:0] cv;
            logic ha_block;
            logic dt_block;
            assign cv = duty_compare_reg[gi*CNT_W +: CNT_W];
            assign raw_match[gi] = (cnt_state.count == cv);
            if (gi == 0) begin : g_cycle
                assign ha_block = (dt1 != '0);
                assign dt_block = 1'b0;
            end else begin : g_duty
                assign ha_block = (cv < dt0) ||
                                  ({1'b0, cv} > upper_ha && cv <= cyc);
                assign dt_block = (cv > cyc) && ({1'b0, cv} <= upper_dt);
            end
            always_comb begin
                next_match[gi] = raw_match[gi];
                if (mode == MODE_HA_TPWM && ha_block) begin
                    next_match[gi] = 1'b0;
                end
                if (mode == MODE_DT_PWM && dt_block) begin
                    next_match[gi] = 1'b0;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Peak, valley, overflow and error
    // ------------------------------------------------------------
    always_comb begin
        next_peak = 1'b0;
        next_valley = 1'b0;
        if (tri_mode) begin
            next_peak = cnt_state.peak_turn & thin_peak_pass;
            next_valley = cnt_state.valley_turn & thin_valley_pass;
        end else if (saw_mode) begin
            next_peak = raw_match[0] & thin_peak_pass;
        end
        next_peak = next_peak & pwm_family;
        next_ovf = 1'b0;
        case (mode)
            MODE_FREE_RUN, MODE_PULSE_MEAS: next_ovf = cnt_state.overflow;
            MODE_HA_TPWM: next_ovf = cnt_state.overflow ||
                                     ({1'b0, dt0} > upper_ha) || (dt1 > cyc);
            default: next_ovf = 1'b0;
        endcase
        next_err = pwm_family & cnt_state.error;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            match_irq <= '0;
            peak_irq <= 1'b0;
            valley_irq <= 1'b0;
            overflow_irq <= 1'b0;
            error_irq <= 1'b0;
        end else begin
            match_irq <= next_match;
            peak_irq <= next_peak;
            valley_irq <= next_valley;
            overflow_irq <= next_ovf;
            error_irq <= next_err;
        end
    end

    // ------------------------------------------------------------
    // A/D trigger controllers and pulse pin
    // ------------------------------------------------------------
    adc_trigger_ctrl u_trig_a (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .enable(pwm_family),
        .select(trigger_a_select),
        .peak_ev(next_peak),
        .cc4_ev(next_match[4]),
        .cc5_ev(next_match[5]),
        .trigger(adc_start_trigger_a)
    );

    adc_trigger_ctrl u_trig_b (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .enable(pwm_family),
        .select(trigger_b_select),
        .peak_ev(next_peak),
        .cc4_ev(next_match[4]),
        .cc5_ev(next_match[5]),
        .trigger(adc_start_trigger_b)
    );

    // The pin follows the trigger pulses one cycle later; clear wins a tie.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            adc_trigger_pulse_pin <= 1'b0;
        end else if (adc_start_trigger_b) begin
            adc_trigger_pulse_pin <= 1'b0;
        end else if (adc_start_trigger_a) begin
            adc_trigger_pulse_pin <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------
    logic [EV_W-1:0] events;
    logic wr_fire;
    logic [5:0] aw_hold;
    logic [31:0] w_hold;
    logic [3:0] strb_hold;
    logic aw_have;
    logic w_have;
    logic [EV_W-1:0] w1c;

    assign events = {adc_start_trigger_b, adc_start_trigger_a, error_irq, overflow_irq,
                     valley_irq, peak_irq, match_irq};
    assign wr_fire = aw_have && w_have && !s_axi_bvalid;
    assign w1c = (wr_fire && aw_hold == ADDR_STATUS[5:0]) ? w_hold[EV_W-1:0] : '0;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status <= '0;
        end else begin
            status <= (status & ~w1c) | events;
        end
    end

    assign irq = |(status & mask);

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_have;
    assign s_axi_wready = !w_have;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_hold <= '0;
            w_hold <= '0;
            strb_hold <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have <= 1'b1;
                aw_hold <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have <= 1'b1;
                w_hold <= s_axi_wdata;
                strb_hold <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_hold)
                    ADDR_CTRL[5:0], ADDR_STATUS[5:0], ADDR_MASK[5:0],
                    ADDR_TRIG_SEL[5:0], ADDR_PIN[5:0]: s_axi_bresp <= RESP_OKAY;
                    default: s_axi_bresp <= RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Byte strobes are honoured only for the mode field (lane 0); fields span at most the low two lanes.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= MODE_INTERVAL;
            mask <= '0;
            trigger_a_select <= '0;
            trigger_b_select <= '0;
        end else if (wr_fire) begin
            case (aw_hold)
                ADDR_CTRL[5:0]: begin
                    if (strb_hold[0]) begin
                        mode <= timer_mode_e'(w_hold[CTRL_MODE_LSB +: CTRL_MODE_W]);
                    end
                end
                ADDR_MASK[5:0]: begin
                    mask <= w_hold[EV_W-1:0];
                end
                ADDR_TRIG_SEL[5:0]: begin
                    trigger_a_select <= w_hold[SEL_W-1:0];
                    trigger_b_select <= w_hold[TRIG_B_LSB +: SEL_W];
                end
                default: begin
                end
            endcase
        end
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case (s_axi_araddr)
                ADDR_CTRL[5:0]: s_axi_rdata <= 32'(mode);
                ADDR_STATUS[5:0]: s_axi_rdata <= 32'(status);
                ADDR_MASK[5:0]: s_axi_rdata <= 32'(mask);
                ADDR_TRIG_SEL[5:0]: s_axi_rdata <= 32'({trigger_b_select, 2'h0,
                                                        trigger_a_select});
                ADDR_PIN[5:0]: s_axi_rdata <= 32'(adc_trigger_pulse_pin);
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence both_trig_s;
        adc_start_trigger_a && adc_start_trigger_b;
    endsequence

    pin_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        adc_start_trigger_a && !adc_start_trigger_b |=> adc_trigger_pulse_pin)
        else $error("pin not set by trigger a");
    pin_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        adc_start_trigger_b |=> !adc_trigger_pulse_pin)
        else $error("pin not cleared by trigger b");
    pin_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !adc_start_trigger_a && !adc_start_trigger_b |=> $stable(adc_trigger_pulse_pin))
        else $error("pin moved without trigger");
    tie_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        both_trig_s |=> !adc_trigger_pulse_pin)
        else $error("tie did not clear pin");
    peak_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        peak_irq |-> $past(pwm_family))
        else $error("peak outside pwm modes");
    valley_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        valley_irq |-> $past(tri_mode))
        else $error("valley outside triangular modes");
    saw_peak_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        saw_mode && raw_match[0] && thin_peak_pass |=> peak_irq && match_irq[0])
        else $error("sawtooth peak not with cycle match");
    cycle_block_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        mode == MODE_HA_TPWM && dt1 != '0 |=> !match_irq[0])
        else $error("cycle match in high accuracy mode");
    trig_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !pwm_family |=> !adc_start_trigger_a && !adc_start_trigger_b)
        else $error("trigger outside pwm modes");
    pulse_once_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(peak_irq) && !cnt_state.peak_turn && !raw_match[0] |=> !peak_irq)
        else $error("peak not a single pulse");

endmodule

// ===== testbench/irq_adc_sink.sv
// Model of the two A/D converters fed by the start trigger outputs.
module irq_adc_sink (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic adc_start_trigger_a,
    input wire logic adc_start_trigger_b,
    output int starts_a,
    output int starts_b
);
    timeunit 1ns;
    timeprecision 1ns;

    // Each converter starts once for every cycle its trigger is high.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            starts_a <= 0;
            starts_b <= 0;
        end else begin
            starts_a <= starts_a + int'(adc_start_trigger_a);
            starts_b <= starts_b + int'(adc_start_trigger_b);
        end
    end
endmodule

// ===== testbench/pwm_timer_event_routing_tb_top.sv
// Self-checking bench of the event routing block.
module pwm_timer_event_routing_tb_top;
    import pwm_event_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [3:0] mode;
        logic [15:0] cnt;
        logic [2:0] pvt;
        logic [15:0] dt1;
        logic [5:0] m;
        logic [1:0] e;
    } row_s;

    localparam counter_state_s IDLE_ST = '{16'h0FFF, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

    logic sys_clk, rst_n, tpp, tvp;
    counter_state_s cs;
    cycle_setting_s cset;
    logic [95:0] duty;
    logic [5:0] aw_addr, ar_addr, match_irq;
    logic aw_valid, aw_ready, w_valid, w_ready, b_valid, b_ready;
    logic ar_valid, ar_ready, r_valid, r_ready;
    logic [31:0] w_data, r_data, rd_d;
    logic [3:0] w_strb;
    logic [1:0] b_resp, r_resp, resp;
    logic peak_irq, valley_irq, overflow_irq, error_irq, trig_a, trig_b, pin, irq, fam;
    int starts_a, starts_b, err_total, check_count, na, nb;
    row_s r;

    row_s rows [15] = '{
        '{MODE_INTERVAL, 16'h001E, 3'h5, 16'h0008, 6'h10, 2'h0},
        '{MODE_PWM, 16'h0064, 3'h1, 16'h0008, 6'h01, 2'h2},
        '{MODE_PWM, 16'h0064, 3'h0, 16'h0008, 6'h01, 2'h0},
        '{MODE_PWM, 16'h0032, 3'h3, 16'h0008, 6'h00, 2'h0},
        '{MODE_TRI_PWM, 16'h0032, 3'h5, 16'h0008, 6'h00, 2'h2},
        '{MODE_TRI_PWM, 16'h0000, 3'h3, 16'h0008, 6'h00, 2'h1},
        '{MODE_HA_TPWM, 16'h0064, 3'h1, 16'h0008, 6'h00, 2'h0},
        '{MODE_HA_TPWM, 16'h0064, 3'h1, 16'h0000, 6'h01, 2'h0},
        '{MODE_HA_TPWM, 16'h0060, 3'h1, 16'h0008, 6'h00, 2'h0},
        '{MODE_HA_TPWM, 16'h000A, 3'h1, 16'h0008, 6'h02, 2'h0},
        '{MODE_DT_PWM, 16'h0069, 3'h1, 16'h0008, 6'h00, 2'h0},
        '{MODE_DT_PWM, 16'h001E, 3'h1, 16'h0008, 6'h10, 2'h0},
        '{MODE_FREE_RUN, 16'h0069, 3'h7, 16'h0008, 6'h20, 2'h0},
        '{MODE_HA_TPWM, 16'h0032, 3'h7, 16'h0008, 6'h00, 2'h3},
        '{MODE_DT_PWM, 16'h0064, 3'h1, 16'h0008, 6'h01, 2'h2}
    };
    logic [15:0] pin_cnt [5] = '{16'h001E, 16'h001E, 16'h0064, 16'h0064, 16'h001E};
    logic pin_exp [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

    pwm_timer_event_routing u_pwm_timer_event_routing (
        .sys_clk(sys_clk), .rst_n(rst_n), .cnt_state(cs), .cycle_set(cset),
        .duty_compare_reg(duty), .thin_peak_pass(tpp), .thin_valley_pass(tvp),
        .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready),
        .s_axi_wdata(w_data), .s_axi_wstrb(w_strb), .s_axi_wvalid(w_valid),
        .s_axi_wready(w_ready), .s_axi_bresp(b_resp), .s_axi_bvalid(b_valid),
        .s_axi_bready(b_ready), .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid),
        .s_axi_arready(ar_ready), .s_axi_rdata(r_data), .s_axi_rresp(r_resp),
        .s_axi_rvalid(r_valid), .s_axi_rready(r_ready), .match_irq(match_irq),
        .peak_irq(peak_irq), .valley_irq(valley_irq), .overflow_irq(overflow_irq),
        .error_irq(error_irq), .adc_start_trigger_a(trig_a), .adc_start_trigger_b(trig_b),
        .adc_trigger_pulse_pin(pin), .irq(irq)
    );

    irq_adc_sink u_irq_adc_sink (
        .sys_clk(sys_clk), .rst_n(rst_n), .adc_start_trigger_a(trig_a),
        .adc_start_trigger_b(trig_b), .starts_a(starts_a), .starts_b(starts_b)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Handshakes are sampled at the falling edge so combinational readies never race.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
        logic aw_hs, w_hs, b_hs;
        @(posedge sys_clk);
        aw_addr <= a[5:0];
        w_data <= d;
        aw_valid <= 1'b1;
        w_valid <= 1'b1;
        b_ready <= 1'b1;
        forever begin
            @(negedge sys_clk);
            aw_hs = aw_valid & aw_ready;
            w_hs = w_valid & w_ready;
            b_hs = b_valid;
            rs = b_resp;
            @(posedge sys_clk);
            if (aw_hs) aw_valid <= 1'b0;
            if (w_hs) w_valid <= 1'b0;
            if (b_hs) begin
                b_ready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        logic ar_hs, r_hs;
        @(posedge sys_clk);
        ar_addr <= a[5:0];
        ar_valid <= 1'b1;
        r_ready <= 1'b1;
        forever begin
            @(negedge sys_clk);
            ar_hs = ar_valid & ar_ready;
            r_hs = r_valid;
            d = r_data;
            rs = r_resp;
            @(posedge sys_clk);
            if (ar_hs) ar_valid <= 1'b0;
            if (r_hs) begin
                r_ready <= 1'b0;
                break;
            end
        end
    endtask

    // One cycle of counter events, then idle; returns once the outputs have settled.
    task automatic pulse(input logic [15:0] c, input logic [3:0] f, input logic t);
        @(posedge sys_clk);
        cs <= '{c, 1'b0, f[3], f[2], f[1], f[0]};
        tpp <= t;
        tvp <= t;
        @(posedge sys_clk);
        cs <= IDLE_ST;
        tpp <= 1'b1;
        tvp <= 1'b1;
        #1;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        finish_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n, tpp, tvp, aw_valid, w_valid, b_ready, ar_valid, r_ready} = 8'h60;
        {aw_addr, ar_addr, w_data, w_strb} = '0;
        w_strb = 4'hF;
        cs = IDLE_ST;
        cset = '{16'h0064, 16'h000A, 16'h0008};
        // Compare 4 stays outside both dead-time windows.
        duty = {16'h0069, 16'h001E, 16'h0060, 16'h0014, 16'h000A, 16'h0064};
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        chk("pin_reset", 32'(pin), 32'h0);
        axi_rd(ADDR_CTRL, rd_d, resp);
        chk("ctrl_reset", rd_d, 32'h0);
        axi_rd(ADDR_TRIG_SEL, rd_d, resp);
        chk("sel_reset", rd_d, 32'h0);
        axi_rd(8'h14, rd_d, resp);
        chk("unmapped_rd", {resp, rd_d[29:0]}, {RESP_SLVERR, 30'h0});
        axi_wr(8'h14, 32'h0000_0001, resp);
        chk("unmapped_wr", 32'(resp), 32'(RESP_SLVERR));
        // Trigger a follows compare 4, trigger b follows the peak.
        axi_wr(ADDR_TRIG_SEL, 32'h0000_0408, resp);
        for (int i = 0; i < 15; i++) begin
            r = rows[i];
            axi_wr(ADDR_CTRL, 32'(r.mode), resp);
            cset.second_dead_time <= r.dt1;
            pulse(r.cnt, {r.pvt[2:1], 2'h0}, r.pvt[0]);
            fam = r.mode inside {MODE_PWM, MODE_TRI_PWM, MODE_HA_TPWM, MODE_DT_PWM};
            chk("match", 32'(match_irq), 32'(r.m));
            chk("peak", 32'(peak_irq), 32'(r.e[1]));
            chk("valley", 32'(valley_irq), 32'(r.e[0]));
            chk("trig_a", 32'(trig_a), 32'(r.m[4] & fam));
            chk("trig_b", 32'(trig_b), 32'(r.e[1] & fam));
            na += int'(r.m[4] & fam);
            nb += int'(r.e[1] & fam);
            @(posedge sys_clk);
            #1;
            chk("one_cycle", 32'({match_irq, peak_irq, valley_irq}), 32'h0);
        end
        chk("starts_a", 32'(starts_a), 32'(na));
        chk("starts_b", 32'(starts_b), 32'(nb));
        axi_wr(ADDR_CTRL, 32'(MODE_PWM), resp);
        for (int i = 0; i < 5; i++) begin
            pulse(pin_cnt[i], 4'h0, 1'b1);
            @(posedge sys_clk);
            #1;
            chk("pin", 32'(pin), 32'(pin_exp[i]));
        end
        axi_rd(ADDR_PIN, rd_d, resp);
        chk("pin_reg", rd_d, 32'h1);
        axi_wr(ADDR_TRIG_SEL, 32'h0000_0808, resp);
        pulse(16'h001E, 4'h0, 1'b1);
        @(posedge sys_clk);
        #1;
        chk("pin_both", 32'(pin), 32'h0);
        // Interrupt status, mask and clear.
        axi_wr(ADDR_STATUS, 32'h0000_0FFF, resp);
        axi_wr(ADDR_CTRL, 32'(MODE_FREE_RUN), resp);
        pulse(16'h0FFF, 4'h2, 1'b1);
        chk("ovf", 32'(overflow_irq), 32'h1);
        axi_rd(ADDR_STATUS, rd_d, resp);
        chk("status", rd_d, 32'h0000_0100);
        chk("irq_masked", 32'(irq), 32'h0);
        axi_wr(ADDR_MASK, 32'h0000_0100, resp);
        #1;
        chk("irq_on", 32'(irq), 32'h1);
        axi_wr(ADDR_STATUS, 32'h0000_0100, resp);
        #1;
        chk("irq_clear", 32'(irq), 32'h0);
        axi_wr(ADDR_CTRL, 32'(MODE_INTERVAL), resp);
        pulse(16'h0FFF, 4'h3, 1'b1);
        chk("no_ovf_err", 32'({overflow_irq, error_irq}), 32'h0);
        axi_wr(ADDR_CTRL, 32'(MODE_PWM), resp);
        pulse(16'h0FFF, 4'h1, 1'b1);
        chk("err", 32'(error_irq), 32'h1);
        axi_wr(ADDR_CTRL, 32'(MODE_HA_TPWM), resp);
        cset.second_dead_time <= 16'h00C8;
        repeat (2) @(posedge sys_clk);
        #1;
        chk("setting_err", 32'(overflow_irq), 32'h1);
        finish_test();
    end
endmodule
